// >>> shared/ocrb_pkg.sv
`default_nettype none
package ocrb_pkg;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int NPIN = 5;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_FN = 6'h22;
  localparam logic [IDX_W-1:0] IDX_SYNC = 6'h23;
  localparam logic [IDX_W-1:0] IDX_BLINK = 6'h33;
  localparam logic [IDX_W-1:0] IDX_DISP = 6'h34;
  localparam logic [IDX_W-1:0] IDX_VSTART = 6'h35;
  localparam logic [IDX_W-1:0] IDX_HSTART = 6'h36;
  localparam logic [IDX_W-1:0] IDX_FRAME_COL = 6'h37;

  // pin_function_enable fields
  localparam int B_PWM_EIGHT_EN = 7;
  localparam int B_BUSCLK = 6;
  localparam int B_BUSDAT = 5;
  localparam int B_CONV2 = 4;
  localparam int B_CONV0 = 2;
  localparam int B_WIN1 = 1;
  localparam int B_WIN0 = 0;

  // sync_interrupt_and_pwm_polarity fields
  localparam int B_FLAG = 7;
  localparam int B_VS_IEN = 6;
  localparam int B_P8INV = 2;
  localparam int B_LOINV = 1;
  localparam int B_HIINV = 0;
  localparam logic [REG_W-1:0] SYNC_WMASK = 8'h47;

  // display_mode_and_polarity fields, and the blink write mask
  localparam int B_VPOL = 2;
  localparam logic [REG_W-1:0] DISP_WMASK = 8'h3f;
  localparam logic [REG_W-1:0] BLINK_WMASK = 8'h0f;

  localparam logic [REG_W-1:0] RST_PIN_FN = 8'h00;
  localparam logic [REG_W-1:0] RST_SYNC = 8'h00;
  localparam logic [REG_W-1:0] RST_BLINK = 8'h03;
  localparam logic [REG_W-1:0] RST_DISP = 8'h02;
  localparam logic [REG_W-1:0] RST_VSTART = 8'h00;
  localparam logic [REG_W-1:0] RST_HSTART = 8'h00;
  localparam logic [REG_W-1:0] RST_FRAME_COL = 8'h00;

  localparam logic [REG_W-1:0] IRQ_VECTOR = 8'h05;

  // Shared pin slots
  localparam int PIN_PWM_EIGHT = 0;
  localparam int PIN_BUSCLK = 1;
  localparam int PIN_BUSDAT = 2;
  localparam int PIN_WIN1 = 3;
  localparam int PIN_WIN0 = 4;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } ocrb_apb_req_s;

  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
  } ocrb_pins_s;

  typedef struct packed {
    logic [REG_W-1:0] blink;
    logic [REG_W-1:0] disp;
    logic [REG_W-1:0] vstart;
    logic [REG_W-1:0] hstart;
    logic [REG_W-1:0] frame_col;
  } ocrb_osd_cfg_s;
endpackage
`default_nettype wire

// >>> design/ocrb_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ocrb_sync (
  input wire logic ref_clk, // Core clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic raw_in, // Asynchronous pin level
  input wire logic active_high, // 1: high is active, 0: low is active
  output logic active_level, // Filtered level, 1 while active
  output logic active_edge // One-cycle pulse when the filtered pin level turns active
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic act;
    logic edg;
  } ocrb_sync_s;

  ocrb_sync_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = raw_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.edg = 1'b0;
    // A change counts only once two late stages agree
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
      // Edge taken on the raw level so a polarity write makes no event
      st_next.edg = (st_reg.s3 != st_reg.lvl) && (st_reg.s3 == active_high);
    end
    st_next.act = st_next.lvl ~^ active_high;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign active_level = st_reg.act;
  assign active_edge = st_reg.edg;

  a_edge_single: assert property (@(posedge ref_clk) disable iff (srst)
    active_edge |=> !active_edge)
    else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> design/ocrb_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ocrb_regs (
  input wire logic ref_clk, // 10 MHz core clock
  input wire logic srst, // Synchronous reset, active high
  input wire ocrb_pkg::ocrb_apb_req_s apb_req, // APB request
  output logic [ocrb_pkg::APB_DW-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [7:0] pwm_gen_in, // Raw PWM 0 to 7
  input wire logic pwm_eight_gen_in, // Raw eighth PWM
  output logic [7:0] pwm_out, // PWM 0 to 7 after polarity
  input wire logic bus_clock_pull_low, // Serial bus drives clock low
  input wire logic bus_data_pull_low, // Serial bus drives data low
  output logic bus_clock_in, // Clock line seen by serial bus
  output logic bus_data_in, // Data line seen by serial bus
  input wire logic window_out0, // Window output 0 from display
  input wire logic window_out1, // Window output 1 from display
  input wire ocrb_pkg::ocrb_pins_s port_drive, // General port drive per pin
  input wire logic [ocrb_pkg::NPIN-1:0] pins_in, // Level on each shared pin
  output ocrb_pkg::ocrb_pins_s pin_drive, // Drive of each shared pin
  output logic [ocrb_pkg::NPIN-1:0] port_lines_in, // Pin levels to port logic
  output logic [2:0] converter_ch_enable, // Converter channels 2..0
  input wire logic vertical_sync_input, // Vsync pin, asynchronous
  output logic vsync_active, // Vsync at its active level
  input wire logic bus_int_enable, // Serial bus interrupt enabled
  input wire logic bus_int_req, // Serial bus interrupt request
  output logic cpu_irq, // Interrupt request to the core
  output logic [ocrb_pkg::REG_W-1:0] irq_vector, // Shared vector
  output ocrb_pkg::ocrb_osd_cfg_s osd_cfg // Display settings
);
  import ocrb_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] pin_fn;
    logic [REG_W-1:0] sync_ctl;
    ocrb_osd_cfg_s cfg;
    ocrb_pins_s pins;
    logic [7:0] pwm;
    logic irq;
    logic [REG_W-1:0] rdata;
  } ocrb_state_s;

  ocrb_state_s st_reg, st_next;

  logic [IDX_W-1:0] idx;
  logic mapped;
  logic setup_rd;
  logic wr_en;
  logic [REG_W-1:0] wbyte;
  logic [NPIN-1:0] sel;
  ocrb_pins_s func;
  logic vs_edge;
  logic vs_level;
  logic flag_clr;

  function automatic logic idx_mapped(input logic [IDX_W-1:0] i);
    logic hit;
    hit = 1'b0;
    case (i)
      IDX_PIN_FN, IDX_SYNC, IDX_BLINK, IDX_DISP,
      IDX_VSTART, IDX_HSTART, IDX_FRAME_COL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [REG_W-1:0] read_reg(input logic [IDX_W-1:0] i,
                                                input ocrb_state_s s);
    logic [REG_W-1:0] v;
    v = '0;
    case (i)
      IDX_PIN_FN: v = s.pin_fn;
      IDX_SYNC: v = s.sync_ctl & SYNC_WMASK | (s.sync_ctl & ~SYNC_WMASK & 8'h80);
      IDX_BLINK: v = s.cfg.blink & BLINK_WMASK;
      IDX_DISP: v = s.cfg.disp & DISP_WMASK;
      IDX_VSTART: v = s.cfg.vstart;
      IDX_HSTART: v = s.cfg.hstart;
      IDX_FRAME_COL: v = s.cfg.frame_col;
      default: v = '0;
    endcase
    return v;
  endfunction

  ocrb_sync u_vsync (
    .ref_clk(ref_clk),
    .srst(srst),
    .raw_in(vertical_sync_input),
    .active_high(st_reg.cfg.disp[B_VPOL]),
    .active_level(vs_level),
    .active_edge(vs_edge)
  );

  // Unmapped or misaligned addresses answer with an error
  assign idx = apb_req.paddr[APB_AW-1:2];
  assign mapped = idx_mapped(idx) && (apb_req.paddr[1:0] == 2'b00);
  assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped;
  assign wbyte = apb_req.pwdata[REG_W-1:0];
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign prdata = {{(APB_DW-REG_W){1'b0}}, st_reg.rdata};

  // Pin slot enables taken from the pin function register
  assign sel[PIN_PWM_EIGHT] = st_reg.pin_fn[B_PWM_EIGHT_EN];
  assign sel[PIN_BUSCLK] = st_reg.pin_fn[B_BUSCLK];
  assign sel[PIN_BUSDAT] = st_reg.pin_fn[B_BUSDAT];
  assign sel[PIN_WIN1] = st_reg.pin_fn[B_WIN1];
  assign sel[PIN_WIN0] = st_reg.pin_fn[B_WIN0];

  // Function side of each pin; bus lines are open drain
  always_comb begin
    func = '0;
    func.out[PIN_PWM_EIGHT] = pwm_eight_gen_in ^ st_reg.sync_ctl[B_P8INV];
    func.oe[PIN_PWM_EIGHT] = 1'b1;
    func.out[PIN_BUSCLK] = 1'b0;
    func.oe[PIN_BUSCLK] = bus_clock_pull_low;
    func.out[PIN_BUSDAT] = 1'b0;
    func.oe[PIN_BUSDAT] = bus_data_pull_low;
    func.out[PIN_WIN1] = window_out1;
    func.oe[PIN_WIN1] = 1'b1;
    func.out[PIN_WIN0] = window_out0;
    func.oe[PIN_WIN0] = 1'b1;
  end

  // Flag clears only on a written zero; a same-cycle edge still wins
  assign flag_clr = wr_en && (idx == IDX_SYNC) && !wbyte[B_FLAG];

  always_comb begin
    st_next = st_reg;
    st_next.rdata = st_reg.rdata;
    // Read data captured in setup so the access phase needs no wait
    if (setup_rd) begin
      st_next.rdata = mapped ? read_reg(idx, st_reg) : '0;
    end
    if (wr_en) begin
      case (idx)
        IDX_PIN_FN: st_next.pin_fn = wbyte;
        IDX_SYNC: st_next.sync_ctl = wbyte & SYNC_WMASK;
        IDX_BLINK: st_next.cfg.blink = wbyte & BLINK_WMASK;
        IDX_DISP: st_next.cfg.disp = wbyte & DISP_WMASK;
        IDX_VSTART: st_next.cfg.vstart = wbyte;
        IDX_HSTART: st_next.cfg.hstart = wbyte;
        IDX_FRAME_COL: st_next.cfg.frame_col = wbyte;
        default: st_next.pin_fn = st_reg.pin_fn;
      endcase
    end
    st_next.sync_ctl[B_FLAG] = (vs_edge && st_reg.sync_ctl[B_VS_IEN])
      || (st_reg.sync_ctl[B_FLAG] && !flag_clr);
    // Level request: an uncleared flag keeps interrupting while B_VS_IEN and bus_int_enable are set
    st_next.irq = bus_int_enable
      && ((st_reg.sync_ctl[B_FLAG] && st_reg.sync_ctl[B_VS_IEN])
      || bus_int_req);
    st_next.pwm[3:0] = pwm_gen_in[3:0] ^ {4{st_reg.sync_ctl[B_LOINV]}};
    st_next.pwm[7:4] = pwm_gen_in[7:4] ^ {4{st_reg.sync_ctl[B_HIINV]}};
    for (int i = 0; i < NPIN; i++) begin
      st_next.pins.out[i] = sel[i] ? func.out[i] : port_drive.out[i];
      st_next.pins.oe[i] = sel[i] ? func.oe[i] : port_drive.oe[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.pin_fn <= RST_PIN_FN;
      st_reg.sync_ctl <= RST_SYNC;
      st_reg.cfg.blink <= RST_BLINK;
      st_reg.cfg.disp <= RST_DISP;
      st_reg.cfg.vstart <= RST_VSTART;
      st_reg.cfg.hstart <= RST_HSTART;
      st_reg.cfg.frame_col <= RST_FRAME_COL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_out = st_reg.pwm;
  assign pin_drive = st_reg.pins;
  assign port_lines_in = pins_in;
  // Serial bus sees an idle high line while its pins are port lines
  assign bus_clock_in = sel[PIN_BUSCLK] ? pins_in[PIN_BUSCLK] : 1'b1;
  assign bus_data_in = sel[PIN_BUSDAT] ? pins_in[PIN_BUSDAT] : 1'b1;
  assign converter_ch_enable = st_reg.pin_fn[B_CONV2:B_CONV0];
  assign vsync_active = vs_level;
  assign cpu_irq = st_reg.irq;
  assign irq_vector = IRQ_VECTOR;
  assign osd_cfg = st_reg.cfg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_unmapped_error:
    assert property (apb_req.psel && apb_req.penable && !mapped |-> pslverr)
    else $error("unmapped access without error");

  a_pwm_eight_route:
    assert property (st_reg.pin_fn[B_PWM_EIGHT_EN] |=>
      pin_drive.out[PIN_PWM_EIGHT] ==
      ($past(pwm_eight_gen_in) ^ $past(st_reg.sync_ctl[B_P8INV])))
    else $error("eighth PWM not on its pin");

  a_busclk_port:
    assert property (!st_reg.pin_fn[B_BUSCLK] |=>
      pin_drive.oe[PIN_BUSCLK] == $past(port_drive.oe[PIN_BUSCLK]))
    else $error("bus clock pin not a port line");

  a_busdat_route:
    assert property (st_reg.pin_fn[B_BUSDAT] && bus_data_pull_low |=>
      pin_drive.oe[PIN_BUSDAT] && !pin_drive.out[PIN_BUSDAT])
    else $error("bus data pin not pulled low");

  a_conv_write:
    assert property (wr_en && idx == IDX_PIN_FN |=>
      converter_ch_enable == $past(wbyte[B_CONV2:B_CONV0]))
    else $error("converter enables not written");

  a_window_route:
    assert property (st_reg.pin_fn[B_WIN0] |=>
      pin_drive.out[PIN_WIN0] == $past(window_out0))
    else $error("window output 0 not on its pin");

  a_flag_set:
    assert property (vs_edge && st_reg.sync_ctl[B_VS_IEN] |=> st_reg.sync_ctl[B_FLAG])
    else $error("flag missed a vsync edge");

  a_flag_clear:
    assert property (flag_clr && !vs_edge |=> !st_reg.sync_ctl[B_FLAG])
    else $error("flag not cleared by written zero");

  a_irq_raise:
    assert property (st_reg.sync_ctl[B_FLAG] && st_reg.sync_ctl[B_VS_IEN]
      && bus_int_enable |=> cpu_irq)
    else $error("vsync interrupt not raised");

  a_irq_blocked:
    assert property (!bus_int_enable |=> !cpu_irq)
    else $error("interrupt raised while bus interrupt disabled");

  a_reserved_zero:
    assert property (setup_rd && idx == IDX_SYNC |=> prdata[5:3] == 3'h0)
    else $error("reserved bits read non-zero");

  a_window_reset:
    assert property ($past(srst) |-> st_reg.pin_fn[B_WIN1:B_WIN0] == 2'h0)
    else $error("window enables set after reset");

  a_pwm_low_inv:
    assert property (st_reg.sync_ctl[B_LOINV] |=>
      pwm_out[3:0] == ~$past(pwm_gen_in[3:0]))
    else $error("low PWM group not inverted");

  a_pwm_high_inv:
    assert property (!st_reg.sync_ctl[B_HIINV] |=>
      pwm_out[7:4] == $past(pwm_gen_in[7:4]))
    else $error("high PWM group wrongly inverted");

  a_pwm_eight_port:
    assert property (!st_reg.pin_fn[B_PWM_EIGHT_EN] |=>
      pin_drive.out[PIN_PWM_EIGHT] == $past(port_drive.out[PIN_PWM_EIGHT]))
    else $error("eighth PWM pin not a port line");

  a_pwm_eight_inv:
    assert property (st_reg.pin_fn[B_PWM_EIGHT_EN] && st_reg.sync_ctl[B_P8INV] |=>
      pin_drive.out[PIN_PWM_EIGHT] != $past(pwm_eight_gen_in))
    else $error("eighth PWM not inverted");

  a_busclk_route:
    assert property (st_reg.pin_fn[B_BUSCLK] |=>
      pin_drive.oe[PIN_BUSCLK] == $past(bus_clock_pull_low) && !pin_drive.out[PIN_BUSCLK])
    else $error("bus clock pin not open drain");

  a_busclk_idle:
    assert property (!st_reg.pin_fn[B_BUSCLK] |-> bus_clock_in)
    else $error("bus clock line not idle high");

  a_busdat_port:
    assert property (!st_reg.pin_fn[B_BUSDAT] |=>
      pin_drive.oe[PIN_BUSDAT] == $past(port_drive.oe[PIN_BUSDAT]))
    else $error("bus data pin not a port line");

  a_window1_route:
    assert property (st_reg.pin_fn[B_WIN1] |=>
      pin_drive.oe[PIN_WIN1] && pin_drive.out[PIN_WIN1] == $past(window_out1))
    else $error("window output 1 not on its pin");

  a_window1_port:
    assert property (!st_reg.pin_fn[B_WIN1] |=>
      pin_drive.out[PIN_WIN1] == $past(port_drive.out[PIN_WIN1]))
    else $error("window 1 pin not a port line");

  a_flag_keep:
    assert property (st_reg.sync_ctl[B_FLAG] && !flag_clr |=> st_reg.sync_ctl[B_FLAG])
    else $error("flag lost without a written zero");

  a_flag_source:
    assert property (!st_reg.sync_ctl[B_FLAG] && !(vs_edge && st_reg.sync_ctl[B_VS_IEN])
      |=> !st_reg.sync_ctl[B_FLAG])
    else $error("flag set without a vsync edge");

  a_irq_bus_req:
    assert property (bus_int_enable && bus_int_req |=> cpu_irq)
    else $error("bus interrupt not raised");

  a_irq_quiet:
    assert property (!(st_reg.sync_ctl[B_FLAG] && st_reg.sync_ctl[B_VS_IEN]) && !bus_int_req
      |=> !cpu_irq)
    else $error("interrupt raised with no source");

  a_pwm_low_pass:
    assert property (!st_reg.sync_ctl[B_LOINV] |=>
      pwm_out[3:0] == $past(pwm_gen_in[3:0]))
    else $error("low PWM group wrongly inverted");

  a_pwm_high_flip:
    assert property (st_reg.sync_ctl[B_HIINV] |=>
      pwm_out[7:4] == ~$past(pwm_gen_in[7:4]))
    else $error("high PWM group not inverted");

  a_sync_reserved:
    assert property (wr_en && idx == IDX_SYNC |=>
      st_reg.sync_ctl[B_VS_IEN-1:B_P8INV+1] == '0)
    else $error("reserved interrupt bits stored");

  a_unmapped_keep:
    assert property (apb_req.psel && apb_req.penable && apb_req.pwrite && !mapped |=>
      st_reg.pin_fn == $past(st_reg.pin_fn) && st_reg.cfg == $past(st_reg.cfg))
    else $error("unmapped write changed a register");

  a_edge_direction:
    assert property (vs_edge |-> vs_level)
    else $error("vsync event not into the active level");

  a_polarity_write:
    assert property (wr_en && idx == IDX_DISP |=>
      st_reg.cfg.disp[B_VPOL] == $past(wbyte[B_VPOL]))
    else $error("vsync polarity not written");
endmodule
`default_nettype wire

// >>> bench/ocrb_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ocrb_regs_bench;
  import ocrb_pkg::*;
  logic ref_clk;
  logic srst;
  ocrb_apb_req_s apb_req;
  logic [APB_DW-1:0] prdata;
  logic pready, pslverr;
  logic [7:0] pwm_gen_in, pwm_out;
  logic pwm_eight_gen_in, bus_clock_pull_low, bus_data_pull_low, bus_clock_in, bus_data_in;
  logic window_out0, window_out1, vertical_sync_input, vsync_active;
  logic bus_int_enable, bus_int_req, cpu_irq;
  ocrb_pins_s port_drive, pin_drive;
  logic [NPIN-1:0] pins_in, port_lines_in;
  logic [2:0] converter_ch_enable;
  logic [REG_W-1:0] irq_vector;
  ocrb_osd_cfg_s osd_cfg;
  int n_fail, total_checks;
  logic [5:0] idx_t [7];
  logic [7:0] rst_t [7];
  logic [7:0] mask_t [7];

  ocrb_regs u_dut (.ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_gen_in(pwm_gen_in),
    .pwm_eight_gen_in(pwm_eight_gen_in),
    .pwm_out(pwm_out), .bus_clock_pull_low(bus_clock_pull_low),
    .bus_data_pull_low(bus_data_pull_low), .bus_clock_in(bus_clock_in),
    .bus_data_in(bus_data_in), .window_out0(window_out0), .window_out1(window_out1),
    .port_drive(port_drive), .pins_in(pins_in), .pin_drive(pin_drive),
    .port_lines_in(port_lines_in), .converter_ch_enable(converter_ch_enable),
    .vertical_sync_input(vertical_sync_input), .vsync_active(vsync_active),
    .bus_int_enable(bus_int_enable), .bus_int_req(bus_int_req), .cpu_irq(cpu_irq),
    .irq_vector(irq_vector), .osd_cfg(osd_cfg));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task stop_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Master holds every request signal until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    // The wait ends when pready is seen high; the watchdog ends it only if ready never comes
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, {idx, 2'b00}, d, rd, e);
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic experr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 8'h00, rd, e);
    chk(rd, {24'h0, exp});
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task pause(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    srst = 1'b1;
    apb_req = '0;
    pwm_gen_in = 8'ha5;
    pwm_eight_gen_in = 1'b1;
    bus_clock_pull_low = 1'b1;
    bus_data_pull_low = 1'b0;
    window_out0 = 1'b0;
    window_out1 = 1'b1;
    port_drive = '{out: 5'h15, oe: 5'h0a};
    pins_in = 5'h15;
    vertical_sync_input = 1'b1;
    bus_int_enable = 1'b1;
    bus_int_req = 1'b0;
    idx_t = '{IDX_PIN_FN, IDX_SYNC, IDX_BLINK, IDX_DISP, IDX_VSTART, IDX_HSTART,
      IDX_FRAME_COL};
    rst_t = '{RST_PIN_FN, RST_SYNC, RST_BLINK, RST_DISP, RST_VSTART, RST_HSTART,
      RST_FRAME_COL};
    mask_t = '{8'hff, SYNC_WMASK, BLINK_WMASK, DISP_WMASK, 8'hff, 8'hff, 8'hff};
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk({idx_t[i], 2'b00}, rst_t[i], 1'b0);
    end
    chk({24'h0, osd_cfg.blink}, {24'h0, RST_BLINK});
    // Reset leaves every shared pin to its port line
    chk({22'h0, pin_drive}, {22'h0, port_drive});
    rd_chk(8'h90, 8'h00, 1'b1);
    rd_chk(8'h89, 8'h00, 1'b1);
    wr(6'h24, 8'hff);
    rd_chk({IDX_PIN_FN, 2'b00}, 8'h00, 1'b0);
    // Flag written with one must stay clear; reserved bits drop
    for (int i = 0; i < 7; i++) begin
      wr(idx_t[i], 8'hff);
      rd_chk({idx_t[i], 2'b00}, mask_t[i], 1'b0);
      wr(idx_t[i], rst_t[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(IDX_PIN_FN, 8'h04 << i);
      pause(2);
      chk({29'h0, converter_ch_enable}, 32'h1 << i);
    end
    wr(IDX_PIN_FN, 8'hff);
    pause(2);
    chk({22'h0, pin_drive}, {22'h0, 5'h09, 5'h1b});
    chk({30'h0, bus_clock_in, bus_data_in}, 32'h1);
    chk({27'h0, port_lines_in}, {27'h0, pins_in});
    for (int k = 0; k < 8; k++) begin
      wr(IDX_SYNC, k[7:0]);
      pause(2);
      chk({24'h0, pwm_out}, {24'h0, 8'ha5 ^ {{4{k[0]}}, {4{k[1]}}}});
      chk({31'h0, pin_drive.out[PIN_PWM_EIGHT]}, {31'h0, ~k[2]});
    end
    wr(IDX_PIN_FN, 8'h00);
    pause(2);
    chk({22'h0, pin_drive}, {22'h0, port_drive});
    chk({30'h0, bus_clock_in, bus_data_in}, 32'h3);
    wr(IDX_SYNC, 8'h40);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b0;
    pause(8);
    chk({31'h0, vsync_active}, 32'h1);
    rd_chk({IDX_SYNC, 2'b00}, 8'hc0, 1'b0);
    chk({31'h0, cpu_irq}, 32'h1);
    chk({24'h0, irq_vector}, {24'h0, IRQ_VECTOR});
    @(posedge ref_clk);
    bus_int_enable <= 1'b0;
    pause(3);
    chk({31'h0, cpu_irq}, 32'h0);
    @(posedge ref_clk);
    bus_int_enable <= 1'b1;
    wr(IDX_SYNC, 8'h40);
    pause(3);
    chk({31'h0, cpu_irq}, 32'h0);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b1;
    pause(8);
    rd_chk({IDX_SYNC, 2'b00}, 8'h40, 1'b0);
    wr(IDX_DISP, RST_DISP | 8'h04);
    pause(8);
    chk({31'h0, vsync_active}, 32'h1);
    rd_chk({IDX_SYNC, 2'b00}, 8'h40, 1'b0);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b0;
    pause(8);
    chk({31'h0, vsync_active}, 32'h0);
    rd_chk({IDX_SYNC, 2'b00}, 8'h40, 1'b0);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b1;
    pause(8);
    rd_chk({IDX_SYNC, 2'b00}, 8'hc0, 1'b0);
    wr(IDX_SYNC, 8'h00);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b0;
    pause(4);
    @(posedge ref_clk);
    vertical_sync_input <= 1'b1;
    bus_int_req <= 1'b1;
    pause(8);
    rd_chk({IDX_SYNC, 2'b00}, 8'h00, 1'b0);
    chk({31'h0, cpu_irq}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
